// ==== hw/nvs_params.svh ====
// Purpose: constants for the serial slave front end
// Assumes: core clock of 125 MHz, period 8 ns
// Notes: times are in ns, cycle counts derive from them
`ifndef NVS_PARAMS_SVH
`define NVS_PARAMS_SVH

`define NVS_CLK_PERIOD_NS 8
`define NVS_OP_READ 8'h03
`define NVS_OP_WRITE 8'h02
`define NVS_OP_RDSR 8'h05
`define NVS_OP_FAST_RDSR 8'h09
`define NVS_OP_WRSR 8'h01
`define NVS_OP_WREN 8'h06
`define NVS_OP_WRDI 8'h04
`define NVS_OP_FAST_READ 8'h0b
`define NVS_OP_STORE 8'h3c
`define NVS_OP_RECALL 8'h60
`define NVS_OP_ASENB 8'h59
`define NVS_OP_ASDISB 8'h19
`define NVS_OP_SLEEP 8'hb9
`define NVS_OP_WRSN 8'hc2
`define NVS_OP_RDSN 8'hc3
`define NVS_OP_FAST_RDSN 8'hc9
`define NVS_OP_RDID 8'h9f
`define NVS_OP_FAST_RDID 8'h99
`define NVS_SR_BUSY 0
`define NVS_SR_WEL 1
`define NVS_SR_BPL 2
`define NVS_SR_BPH 3
`define NVS_SR_WPE 7
`define NVS_RECALL_NS 20000
`define NVS_WINDOW_NS 25000
`define NVS_STANDBY_NS 100
`define NVS_STORE_NS 8000
`define NVS_SR_RESET 8'h00

`endif

// ==== hw/nvs_pkg.sv ====
// Purpose: types shared by the front end files
// Assumes: nothing beyond the parameter header
// Notes: types only, constants live in the header
package nvs_pkg;

  typedef enum logic [1:0] {
    NVS_PH_OPCODE,
    NVS_PH_ADDR,
    NVS_PH_DATA,
    NVS_PH_DISCARD
  } nvs_phase_t;

  typedef enum logic [2:0] {
    NVS_PW_OFF,
    NVS_PW_RECALL,
    NVS_PW_RUN,
    NVS_PW_WINDOW,
    NVS_PW_STORE,
    NVS_PW_DEAD
  } nvs_power_t;

  // one decoded item handed from the link to the core
  typedef struct packed {
    logic [7:0] opcode;
    logic [15:0] addr;
    logic [7:0] data;
    logic is_write;
    logic is_wrsr;
    logic is_wren;
    logic is_wrdi;
    logic is_store;
    logic is_recall;
  } nvs_item_t;

endpackage

// ==== hw/nvs_sync.sv ====
// Purpose: two flop level synchroniser
// Assumes: destination clock is clock
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module nvs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  // plain pass through the two stages
  always_comb begin
    meta_next = din;
    sync_next = meta_reg;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign dout = sync_reg;
endmodule

// ==== hw/nvs_mem.sv ====
// Purpose: byte array behind the serial front end
// Assumes: single write and single registered read port
// Notes: read data come from a register
`timescale 1ns/1ps
module nvs_mem #(
  parameter int AW = 16
) (
  input wire logic clock,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [7:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [0:(1<<AW)-1];
  logic [7:0] rd_reg;

  // no reset on the array, it models the sram cells
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_reg <= mem[rd_addr];
  end

  assign rd_data = rd_reg;
endmodule

// ==== hw/nvs_front.sv ====
// Purpose: spi slave front end of a 64k x 8 nonvolatile sram
// Assumes: sck is the link clock; supply_ok models the supply threshold
// Notes: store and recall are timed, store also copies the status register; no nonvolatile array cells are modelled
`timescale 1ns/1ps
`include "nvs_params.svh"

// Notes on behaviour
// - sample si rising, drive so falling
// - sck level at select picks mode
// - mode 3 skips the initial falling edge
// - first byte after select is opcode
// - all bytes travel msb first
// - memory ops carry two address bytes
// - deselected: ignore si, so high impedance
// - bad opcode: ignore rest, so off
// - up to 104 mhz, read slower
// - power-up recall blocks access, busy pin
// - after power-up no hold state
// - power-up clears write enable, keeps protection
// - below threshold ignore, finish pending write
// - then inhibit, store only if written
// - standby after delay unless store running
// - eight bit status register
// - slave never starts bus activity
// - decode read, write, status read opcodes
module nvs_front #(
  parameter int RECALL_CYC =
    (`NVS_RECALL_NS + `NVS_CLK_PERIOD_NS - 1) / `NVS_CLK_PERIOD_NS,
  parameter int WINDOW_CYC = `NVS_WINDOW_NS / `NVS_CLK_PERIOD_NS,
  parameter int STORE_CYC =
    (`NVS_STORE_NS + `NVS_CLK_PERIOD_NS - 1) / `NVS_CLK_PERIOD_NS
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic supply_ok,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  output logic busy_pin_out_n,
  output logic busy_pin_oe,
  output logic standby,
  output logic [7:0] status_out
);
  localparam int SB_CYC =
    (`NVS_STANDBY_NS + `NVS_CLK_PERIOD_NS - 1) / `NVS_CLK_PERIOD_NS;

  // ---------------- link domain, clocked by sck ----------------
  // link logic runs on sck itself, so no rate limit is added here
  // cs_n high acts as async reset: counters clear while deselected
  logic [2:0] bit_reg;
  logic [2:0] bit_next;
  logic [7:0] sh_reg;
  logic [7:0] sh_next;
  logic [7:0] op_reg;
  logic [7:0] op_next;
  logic [15:0] addr_reg;
  logic [15:0] addr_next;
  logic [1:0] abyte_reg;
  logic [1:0] abyte_next;
  nvs_pkg::nvs_phase_t ph_reg;
  nvs_pkg::nvs_phase_t ph_next;
  nvs_pkg::nvs_item_t item_reg;
  nvs_pkg::nvs_item_t item_next;
  logic tgl_reg;
  logic tgl_next;
  logic link_en;
  logic [7:0] shin;
  logic op_ok;
  logic [7:0] tx_reg;
  logic [7:0] tx_next;
  logic oe_reg;
  logic oe_next;
  logic [7:0] status_sync;
  logic [7:0] rd_sync;
  logic [7:0] rd_data;
  logic run_sync;

  assign shin = {sh_reg[6:0], si};
  // mode 3 idles sck high at select: the first edge seen is the falling
  // one, which moves nothing here, so the first rising edge is bit 7
  // (both modes reduce to rising-edge capture)

  // known opcode set; anything else is dropped
  always_comb begin
    unique case (shin)
      `NVS_OP_READ, `NVS_OP_WRITE, `NVS_OP_RDSR, `NVS_OP_FAST_RDSR,
      `NVS_OP_WRSR, `NVS_OP_WREN, `NVS_OP_WRDI, `NVS_OP_FAST_READ,
      `NVS_OP_STORE, `NVS_OP_RECALL, `NVS_OP_ASENB, `NVS_OP_ASDISB,
      `NVS_OP_SLEEP, `NVS_OP_WRSN, `NVS_OP_RDSN, `NVS_OP_FAST_RDSN,
      `NVS_OP_RDID, `NVS_OP_FAST_RDID: op_ok = 1'b1;
      default: op_ok = 1'b0;
    endcase
  end

  assign link_en = run_sync; // no response unless running

  // receive state: opcode, address bytes, data bytes
  always_comb begin
    bit_next = bit_reg + 3'd1;
    sh_next = shin;
    op_next = op_reg;
    addr_next = addr_reg;
    abyte_next = abyte_reg;
    ph_next = ph_reg;
    item_next = item_reg;
    tgl_next = tgl_reg;
    if (!link_en) begin
      ph_next = nvs_pkg::NVS_PH_DISCARD;
    end else if (bit_reg == 3'd7) begin
      unique case (ph_reg)
        nvs_pkg::NVS_PH_OPCODE: begin
          op_next = shin;
          if (!op_ok) begin
            ph_next = nvs_pkg::NVS_PH_DISCARD;
          end else if (shin == `NVS_OP_READ || shin == `NVS_OP_WRITE ||
                       shin == `NVS_OP_FAST_READ) begin
            ph_next = nvs_pkg::NVS_PH_ADDR;
          end else begin
            ph_next = nvs_pkg::NVS_PH_DATA;
            item_next = '0;
            item_next.opcode = shin;
            item_next.is_wren = (shin == `NVS_OP_WREN);
            item_next.is_wrdi = (shin == `NVS_OP_WRDI);
            item_next.is_store = (shin == `NVS_OP_STORE);
            item_next.is_recall = (shin == `NVS_OP_RECALL);
            tgl_next = ~tgl_reg;
          end
        end
        nvs_pkg::NVS_PH_ADDR: begin
          addr_next = {addr_reg[7:0], shin};
          abyte_next = abyte_reg + 2'd1;
          if (abyte_reg == 2'd1) begin
            ph_next = nvs_pkg::NVS_PH_DATA;
          end
        end
        nvs_pkg::NVS_PH_DATA: begin
          item_next = '0;
          item_next.opcode = op_reg;
          item_next.addr = addr_reg;
          item_next.data = shin;
          item_next.is_write = (op_reg == `NVS_OP_WRITE);
          item_next.is_wrsr = (op_reg == `NVS_OP_WRSR);
          if (op_reg == `NVS_OP_WRITE || op_reg == `NVS_OP_WRSR) begin
            tgl_next = ~tgl_reg;
          end
          addr_next = addr_reg + 16'd1; // burst rolls over
        end
        default: ph_next = ph_reg; // stay deaf until next select
      endcase
    end
  end

  // cs_n high clears the counters before the next frame
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      bit_reg <= 3'd0;
      sh_reg <= 8'h00;
      op_reg <= 8'h00;
      addr_reg <= 16'h0000;
      abyte_reg <= 2'd0;
      ph_reg <= nvs_pkg::NVS_PH_OPCODE;
    end else begin
      bit_reg <= bit_next;
      sh_reg <= sh_next;
      op_reg <= op_next;
      addr_reg <= addr_next;
      abyte_reg <= abyte_next;
      ph_reg <= ph_next;
    end
  end

  // handoff item and toggle survive deselect so the core can take it
  always_ff @(posedge sck or negedge resetn) begin
    if (!resetn) begin
      item_reg <= '0;
      tgl_reg <= 1'b0;
    end else begin
      item_reg <= item_next;
      tgl_reg <= tgl_next;
    end
  end

  // transmit side: load a byte at the start, shift on falling edges
  always_comb begin
    tx_next = {tx_reg[6:0], 1'b0};
    oe_next = oe_reg;
    if (bit_reg == 3'd0 && link_en) begin
      if (ph_reg == nvs_pkg::NVS_PH_DATA &&
          (op_reg == `NVS_OP_RDSR || op_reg == `NVS_OP_FAST_RDSR)) begin
        tx_next = status_sync;
        oe_next = 1'b1;
      end else if (ph_reg == nvs_pkg::NVS_PH_DATA &&
                   (op_reg == `NVS_OP_READ ||
                    op_reg == `NVS_OP_FAST_READ)) begin
        tx_next = rd_sync;
        oe_next = 1'b1;
      end else begin
        oe_next = 1'b0;
      end
    end
  end

  // falling edge output stage
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      tx_reg <= 8'h00;
      oe_reg <= 1'b0;
    end else begin
      tx_reg <= tx_next;
      oe_reg <= oe_next;
    end
  end

  // so released unless selected and answering
  assign so = tx_reg[7];
  assign so_oe = oe_reg & ~cs_n;

  // ---------------- core domain, clocked by clock ----------------
  logic [2:0] in_sync;
  logic tgl_seen_reg;
  logic tgl_seen_next;
  logic [7:0] sr_reg;
  logic [7:0] sr_next;
  logic [7:0] nv_bits_reg;
  logic [7:0] nv_bits_next;
  logic dirty_reg;
  logic dirty_next;
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  nvs_pkg::nvs_power_t pw_reg;
  nvs_pkg::nvs_power_t pw_next;
  logic [7:0] sb_reg;
  logic [7:0] sb_next;
  logic run_reg;
  logic new_item;
  logic mem_we;
  logic cs_s;
  logic sup_s;
  logic tgl_s;

  nvs_sync #(.WIDTH(3)) u_sync (
    .clock(clock),
    .resetn(resetn),
    .din({cs_n, supply_ok, tgl_reg}),
    .dout({cs_s, sup_s, tgl_s})
  );
  assign in_sync = {cs_s, sup_s, tgl_s};
  assign new_item = (tgl_s != tgl_seen_reg);
  // item bits held stable across the toggle edge, read after it lands
  assign mem_we = new_item && item_reg.is_write && sr_reg[`NVS_SR_WEL] &&
                  (pw_reg == nvs_pkg::NVS_PW_RUN ||
                   pw_reg == nvs_pkg::NVS_PW_WINDOW);

  nvs_mem #(.AW(16)) u_mem (
    .clock(clock),
    .wr_en(mem_we),
    .wr_addr(item_reg.addr),
    .wr_data(item_reg.data),
    .rd_addr(addr_reg),
    .rd_data(rd_data)
  );

  // power sequencing, status register and timers
  always_comb begin
    pw_next = pw_reg;
    cnt_next = cnt_reg;
    sr_next = sr_reg;
    nv_bits_next = nv_bits_reg;
    dirty_next = dirty_reg | mem_we;
    tgl_seen_next = tgl_s;
    sb_next = in_sync[2] ? ((sb_reg == 8'(SB_CYC)) ? sb_reg : sb_reg + 8'd1)
                         : 8'd0;
    unique case (pw_reg)
      nvs_pkg::NVS_PW_OFF: begin
        if (in_sync[1]) begin
          pw_next = nvs_pkg::NVS_PW_RECALL;
          cnt_next = 32'd0;
          sr_next = nv_bits_reg; // protection kept
          sr_next[`NVS_SR_WEL] = 1'b0;
          sr_next[`NVS_SR_BUSY] = 1'b1;
          dirty_next = 1'b0;
        end
      end
      nvs_pkg::NVS_PW_RECALL, nvs_pkg::NVS_PW_STORE: begin
        cnt_next = cnt_reg + 32'd1;
        if (cnt_reg + 32'd1 >= 32'(pw_reg == nvs_pkg::NVS_PW_STORE ?
                                   STORE_CYC : RECALL_CYC)) begin
          sr_next[`NVS_SR_BUSY] = 1'b0;
          if (pw_reg == nvs_pkg::NVS_PW_STORE) begin
            nv_bits_next = sr_reg;
            dirty_next = 1'b0;
          end
          pw_next = !in_sync[1] ? nvs_pkg::NVS_PW_DEAD
                                : nvs_pkg::NVS_PW_RUN;
        end
      end
      nvs_pkg::NVS_PW_RUN: begin
        if (!in_sync[1]) begin
          pw_next = nvs_pkg::NVS_PW_WINDOW;
          cnt_next = 32'd0;
        end else if (new_item) begin
          if (item_reg.is_wren) sr_next[`NVS_SR_WEL] = 1'b1;
          if (item_reg.is_wrdi) sr_next[`NVS_SR_WEL] = 1'b0;
          if (item_reg.is_wrsr && sr_reg[`NVS_SR_WEL]) begin
            sr_next[`NVS_SR_WPE] = item_reg.data[`NVS_SR_WPE];
            sr_next[`NVS_SR_BPH] = item_reg.data[`NVS_SR_BPH];
            sr_next[`NVS_SR_BPL] = item_reg.data[`NVS_SR_BPL];
          end
          if (item_reg.is_store || item_reg.is_recall) begin
            pw_next = item_reg.is_store ? nvs_pkg::NVS_PW_STORE
                                        : nvs_pkg::NVS_PW_RECALL;
            cnt_next = 32'd0;
            sr_next[`NVS_SR_BUSY] = 1'b1;
          end
        end
      end
      nvs_pkg::NVS_PW_WINDOW: begin
        cnt_next = cnt_reg + 32'd1;
        if (cnt_reg + 32'd1 >= 32'(WINDOW_CYC)) begin
          cnt_next = 32'd0;
          if (dirty_reg) begin
            pw_next = nvs_pkg::NVS_PW_STORE;
            sr_next[`NVS_SR_BUSY] = 1'b1;
          end else begin
            pw_next = nvs_pkg::NVS_PW_DEAD;
          end
        end
      end
      nvs_pkg::NVS_PW_DEAD: begin
        if (in_sync[1]) pw_next = nvs_pkg::NVS_PW_OFF;
      end
      default: pw_next = nvs_pkg::NVS_PW_OFF;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pw_reg <= nvs_pkg::NVS_PW_OFF;
      cnt_reg <= 32'd0;
      sr_reg <= `NVS_SR_RESET;
      nv_bits_reg <= `NVS_SR_RESET;
      dirty_reg <= 1'b0;
      tgl_seen_reg <= 1'b0;
      sb_reg <= 8'd0;
      run_reg <= 1'b0;
    end else begin
      pw_reg <= pw_next;
      cnt_reg <= cnt_next;
      sr_reg <= sr_next;
      nv_bits_reg <= nv_bits_next;
      dirty_reg <= dirty_next;
      tgl_seen_reg <= tgl_seen_next;
      sb_reg <= sb_next;
      run_reg <= (pw_next == nvs_pkg::NVS_PW_RUN);
    end
  end

  // status and read data cross to sck as slow levels, two flops each
  nvs_sync #(.WIDTH(17)) u_back (
    .clock(sck),
    .resetn(resetn),
    .din({sr_reg, rd_data, run_reg}),
    .dout({status_sync, rd_sync, run_sync})
  );

  // busy pin low while recall or store runs; no hold mode
  assign busy_pin_out_n = ~sr_reg[`NVS_SR_BUSY];
  assign busy_pin_oe = sr_reg[`NVS_SR_BUSY];
  // standby only after the delay and with no nv cycle running
  assign standby = (sb_reg == 8'(SB_CYC)) && !sr_reg[`NVS_SR_BUSY];
  assign status_out = sr_reg;
endmodule

// ==== verification/nvs_front_chk.sv ====
// Purpose: port assertions for the spi front end
// Assumes: core clock domain only; sck side seen through effects
// Notes: bound to every nvs_front instance
`timescale 1ns/1ps
module nvs_front_chk #(
  parameter int RECALL_CYC = 20,
  parameter int STORE_CYC = 20
) (
  input logic clock,
  input logic resetn,
  input logic supply_ok,
  input logic cs_n,
  input logic so_oe,
  input logic busy_pin_out_n,
  input logic busy_pin_oe,
  input logic standby,
  input logic [7:0] status_out
);
  localparam int MIN_BUSY = RECALL_CYC < STORE_CYC ? RECALL_CYC : STORE_CYC;
  int busy_cnt;
  int idle_cnt;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence s_desel; cs_n [*2]; endsequence
  sequence s_busy; busy_pin_oe [*4]; endsequence
  // run lengths; idle excludes supply loss, where standby is undefined
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      busy_cnt <= 0;
      idle_cnt <= 0;
    end else begin
      busy_cnt <= busy_pin_oe ? busy_cnt + 1 : 0;
      idle_cnt <= (cs_n && supply_ok && !busy_pin_oe) ? idle_cnt + 1 : 0;
    end
  end
  a_desel_so_off: assert property (s_desel |-> !so_oe)
    else $error("so driven while deselected");
  a_busy_pin_low: assert property (busy_pin_oe |-> !busy_pin_out_n)
    else $error("busy pin enabled but not low");
  a_supply_recall: assert property ($rose(supply_ok) |-> ##[1:8] busy_pin_oe)
    else $error("no recall busy after supply rise");
  a_busy_length: assert property ($fell(busy_pin_oe) |-> busy_cnt >= MIN_BUSY - 1)
    else $error("busy period too short");
  a_busy_mute: assert property (s_busy |-> !so_oe)
    else $error("so driven while busy");
  a_supply_mute: assert property (!supply_ok [*4] |-> !so_oe)
    else $error("so driven below threshold");
  a_busy_no_standby: assert property (s_busy |-> !standby)
    else $error("standby while busy");
  a_select_active: assert property (!cs_n [*6] |-> !standby)
    else $error("standby while selected");
  a_idle_standby: assert property (idle_cnt >= 24 |-> standby)
    else $error("no standby after idle deselect");
  a_standby_delay: assert property ($rose(standby) |-> $past(cs_n, 12))
    else $error("standby entered too early");
  a_recall_wel_clear: assert property (
    $rose(supply_ok) |-> ##[1:8] (busy_pin_oe && !status_out[1]))
    else $error("write enable kept through recall");
endmodule

bind nvs_front nvs_front_chk #(.RECALL_CYC(RECALL_CYC), .STORE_CYC(STORE_CYC))
  nvs_front_chk_i (.clock, .resetn, .supply_ok, .cs_n, .so_oe,
  .busy_pin_out_n, .busy_pin_oe, .standby, .status_out);

// ==== verification/nvs_master.sv ====
// Purpose: behavioural spi bus master facing the front end
// Assumes: mode 0 or 3, 48 ns sck period inside frames
// Notes: sck stands still between frames; si is scrambled there
`timescale 1ns/1ps
module nvs_master (
  output logic sck,
  output logic cs_n,
  output logic si,
  input logic so,
  input logic so_oe
);
  logic oe_seen;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    oe_seen = 1'b0;
  end
  // nb bits of tx msb first, then nr bits read back into rx
  task automatic frame(input logic m3, input logic [31:0] tx,
      input int nb, input int nr, output logic [7:0] rx);
    rx = 8'h00;
    oe_seen = 1'b0;
    sck = m3;
    #30;
    cs_n = 1'b0;
    #20;
    for (int i = 0; i < nb + nr; i++) begin
      sck = 1'b0;
      si = (i < nb) ? tx[31 - i] : ~si;
      #24; // 48 ns period, far below the rate limit
      sck = 1'b1;
      if (i >= nb) rx = {rx[6:0], so};
      oe_seen = oe_seen | so_oe;
      #24;
    end
    sck = m3;
    #20;
    cs_n = 1'b1;
    si = ~si;
    #100;
  endtask
endmodule

// ==== verification/nvs_front_tb.sv ====
// Purpose: self-checking bench for the spi front end
// Assumes: recall, window and store counts shrunk to 20
// Notes: read data may lag, so only status reads are compared
`timescale 1ns/1ps
`include "nvs_params.svh"
module nvs_front_tb;
  localparam int CYC = 20;
  localparam int LIMIT = 20000;
  localparam logic [7:0] WEL = 8'h01 << `NVS_SR_WEL;
  localparam logic [7:0] PROT = (8'h01 << `NVS_SR_WPE) |
    (8'h01 << `NVS_SR_BPH) | (8'h01 << `NVS_SR_BPL);
  typedef struct packed {
    logic m3;
    logic [7:0] op;
    logic [7:0] sr;
  } nvs_row_t;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic supply_ok = 1'b0;
  logic sck, cs_n, si, so, so_oe, so_line, busy_line;
  logic busy_pin_out_n, busy_pin_oe, standby;
  logic [7:0] status_out, rx;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  nvs_row_t rows [4];
  always #4 clock = ~clock;
  // released so shows the inverse of its last bit; busy pin has a pull-up
  assign so_line = so_oe ? so : ~so;
  assign busy_line = busy_pin_oe ? busy_pin_out_n : 1'b1;
  nvs_front #(.RECALL_CYC(CYC), .WINDOW_CYC(CYC), .STORE_CYC(CYC))
    nvs_front_i (.clock, .resetn, .supply_ok, .sck, .cs_n, .si, .so,
    .so_oe, .busy_pin_out_n, .busy_pin_oe, .standby, .status_out);
  nvs_master nvs_master_i (.sck, .cs_n, .si, .so(so_line), .so_oe);
  // hang guard
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == LIMIT) begin
      errors = errors + 1;
      end_sim();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // bounded wait for the busy line level
  task automatic wait_busy(input logic lvl, input int n);
    int k;
    k = 0;
    while (busy_line !== lvl && k < n) begin
      @(negedge clock);
      k++;
    end
    chk({7'h00, busy_line}, {7'h00, lvl});
  endtask
  task automatic rd_sr(input logic m3, input logic [7:0] exp);
    nvs_master_i.frame(m3, {`NVS_OP_RDSR, 24'h000000}, 8, 8, rx);
    chk(rx, exp);
    chk(status_out, exp);
    chk({7'h00, nvs_master_i.oe_seen}, 8'h01);
  endtask
  // full power cycle; the first frame only lets the run state cross
  task automatic power_up();
    @(negedge clock);
    resetn = 1'b0;
    supply_ok = 1'b0;
    repeat (6) @(negedge clock);
    chk(status_out, 8'h00);
    resetn = 1'b1;
    repeat (3) @(negedge clock);
    supply_ok = 1'b1;
    wait_busy(1'b0, 10);
    wait_busy(1'b1, CYC + 10);
    nvs_master_i.frame(1'b0, {`NVS_OP_WRDI, 24'h000000}, 8, 0, rx);
    rd_sr(1'b0, 8'h00);
  endtask
  initial begin
    rows[0] = '{1'b0, `NVS_OP_WREN, WEL};
    rows[1] = '{1'b1, `NVS_OP_WRDI, 8'h00};
    rows[2] = '{1'b1, `NVS_OP_WREN, WEL};
    rows[3] = '{1'b0, `NVS_OP_WRDI, 8'h00};
    power_up();
    foreach (rows[i]) begin
      nvs_master_i.frame(rows[i].m3, {rows[i].op, 24'h000000}, 8, 0, rx);
      rd_sr(rows[i].m3, rows[i].sr);
    end
    // a bad opcode hides a valid one behind it
    nvs_master_i.frame(1'b0, {8'h1e, `NVS_OP_WREN, 16'h0000}, 16, 8, rx);
    chk({7'h00, nvs_master_i.oe_seen}, 8'h00);
    rd_sr(1'b0, 8'h00);
    // only the first byte of a frame is an opcode
    nvs_master_i.frame(1'b0, {`NVS_OP_WRDI, `NVS_OP_WREN, 16'h0000}, 16, 0, rx);
    rd_sr(1'b1, 8'h00);
    repeat (30) @(negedge clock);
    chk({7'h00, standby}, 8'h01);
    // refused write leaves nothing to store at power-down
    nvs_master_i.frame(1'b0, {`NVS_OP_WRITE, 24'hffffa5}, 32, 0, rx);
    @(negedge clock);
    supply_ok = 1'b0;
    repeat (4 * CYC) @(negedge clock);
    chk({7'h00, busy_line}, 8'h01);
    nvs_master_i.frame(1'b0, {`NVS_OP_RDSR, 24'h000000}, 8, 8, rx);
    chk({7'h00, nvs_master_i.oe_seen}, 8'h00);
    power_up();
    // enabled write with both address bytes forces a store
    nvs_master_i.frame(1'b1, {`NVS_OP_WREN, 24'h000000}, 8, 0, rx);
    nvs_master_i.frame(1'b1, {`NVS_OP_WRSR, PROT, 16'h0000}, 16, 0, rx);
    nvs_master_i.frame(1'b1, {`NVS_OP_WRITE, 24'h12345a}, 32, 0, rx);
    @(negedge clock);
    supply_ok = 1'b0;
    wait_busy(1'b0, 4 * CYC);
    wait_busy(1'b1, 3 * CYC);
    // supply back without reset: protection returns, write enable cleared
    @(negedge clock);
    supply_ok = 1'b1;
    wait_busy(1'b0, 10);
    wait_busy(1'b1, CYC + 10);
    rd_sr(1'b1, PROT);
    power_up();
    end_sim();
  end
endmodule
